/* File: bitrev_and_program_space_agu.v */
/*
 * X write address generation with bit-reversed modification, and program
 * space address construction for table and visibility accesses, with an
 * AXI4-Lite register slave.
 * Assumes pipeline requests on aclk, one cycle wide, and one outstanding
 * bus read and write at a time.
 */
// Operation
// - Bit reversal needs selector not 15, enable set, and pre/post increment.
// - Pivot modifier held in bits 14:0 of bit reverse control.
// - Reversed addresses are word addresses, bit 0 clear, pivot scaled to bytes.
// - Reversal only on word writes with pre or post increment.
// - Reversal adds reversed pivot to pointer, ignores increment, clears bit 0.
// - Reversal beats circular correction on X write; X read keeps circular.
// - Sixteen entry buffer reverses four index bits, 1 to 8, 3 to 12.
// - Table address is table page above 16-bit effective address.
// - Table page bit 7 picks user or configuration memory.
// - Upper half data address maps to visibility page plus low 15 bits.
// - Visibility accesses stay in user memory, program bit 23 zero.
// - Program bit 15 comes from visibility page bit 0.
// - Visibility accesses are read only and give the low word.
// - Table instructions reach every byte of program words, reading and writing.
// - Reversal only on the X generator and only for data writes.
// - Remapping only while visibility enable, core control bit 2, is set.
`timescale 1ns/1ps
`include "agu_defs.vh"

module bitrev_and_program_space_agu #(
  parameter ADDR_W = 8
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] awaddr,
  input  wire [2:0]        awprot,
  input  wire              awvalid,
  output wire              awready,
  input  wire [31:0]       wdata,
  input  wire [3:0]        wstrb,
  input  wire              wvalid,
  output wire              wready,
  output reg  [1:0]        bresp,
  output reg               bvalid,
  input  wire              bready,
  input  wire [ADDR_W-1:0] araddr,
  input  wire [2:0]        arprot,
  input  wire              arvalid,
  output wire              arready,
  output reg  [31:0]       rdata,
  output reg  [1:0]        rresp,
  output reg               rvalid,
  input  wire              rready,
  input  wire              xw_req,
  input  wire [3:0]        xw_ptr_num,
  input  wire [15:0]       xw_ptr,
  input  wire [2:0]        xw_mode,
  input  wire              xw_byte,
  output reg               xw_done,
  output reg  [15:0]       xw_ea,
  output reg  [15:0]       xw_ptr_next,
  output reg               xw_ptr_wb,
  output reg               xw_bitrev_used,
  output reg               xw_modulo_en,
  output reg               xr_modulo_en,
  input  wire              pa_req,
  input  wire              pa_table,
  input  wire              pa_write,
  input  wire [15:0]       pa_ea,
  output reg               pa_done,
  output reg  [23:0]       prog_addr,
  output reg               prog_config,
  output reg               prog_psv,
  output reg               prog_write,
  output reg               prog_refused
);

  // ========================================================================
  // Register state
  reg  [15:0] addressing_mode_control;
  reg  [15:0] bit_reverse_control;
  reg  [7:0]  table_page;
  reg  [7:0]  visibility_page;
  reg  [15:0] core_control;

  wire [3:0]  bitrev_pointer_select;
  wire        bitrev_enable;
  wire [14:0] pivot_modifier;
  wire        visibility_enable;
  wire        xmod_on;
  wire [3:0]  xmod_ptr;

  assign bitrev_pointer_select = addressing_mode_control[`SEL_HI:`SEL_LO];
  assign xmod_on               = addressing_mode_control[`XMOD_EN_BIT];
  assign xmod_ptr              = addressing_mode_control[`XMOD_PTR_HI:`XMOD_PTR_LO];
  assign bitrev_enable         = bit_reverse_control[`BITREV_EN_BIT];
  assign pivot_modifier        = bit_reverse_control[`PIVOT_HI:`PIVOT_LO];
  assign visibility_enable     = core_control[`VIS_EN_BIT];

  // ========================================================================
  // Register decode, shared by the read and write paths
  function [2:0] reg_code;
    input [ADDR_W-1:0] a;
    begin
      case (a[7:0])
        `OFS_MODE_CTRL:   reg_code = 3'h1;
        `OFS_BITREV_CTRL: reg_code = 3'h2;
        `OFS_TABLE_PAGE:  reg_code = 3'h3;
        `OFS_VIS_PAGE:    reg_code = 3'h4;
        `OFS_CORE_CTRL:   reg_code = 3'h5;
        `OFS_LAST_PROG:   reg_code = 3'h6;
        `OFS_LAST_XW:     reg_code = 3'h7;
        default:          reg_code = 3'h0;
      endcase
    end
  endfunction

  function [15:0] merge16;
    input [15:0] old;
    input [31:0] d;
    input [3:0]  s;
    begin
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    end
  endfunction

  // ========================================================================
  // AXI4-Lite write channel
  // Address and data are taken together; either arriving alone waits.
  wire       wr_take;
  wire [2:0] wr_code;

  assign wr_take = awvalid && wvalid && !bvalid;
  assign awready = wr_take;
  assign wready  = wr_take;
  assign wr_code = reg_code(awaddr);

  always @(posedge aclk) begin
    if (!aresetn) begin
      addressing_mode_control <= `RST_MODE_CTRL;
      bit_reverse_control     <= `RST_BITREV_CTRL;
      table_page              <= `RST_TABLE_PAGE;
      visibility_page         <= `RST_VIS_PAGE;
      core_control            <= `RST_CORE_CTRL;
      bvalid                  <= 1'b0;
      bresp                   <= `RESP_OKAY;
    end else begin
      if (wr_take) begin
        bvalid <= 1'b1;
        bresp  <= (wr_code == 3'h0) ? `RESP_SLVERR : `RESP_OKAY;
        case (wr_code)
          3'h1: addressing_mode_control <= merge16(addressing_mode_control, wdata, wstrb);
          3'h2: bit_reverse_control     <= merge16(bit_reverse_control, wdata, wstrb);
          3'h3: table_page              <= wstrb[0] ? wdata[7:0] : table_page;
          3'h4: visibility_page         <= wstrb[0] ? wdata[7:0] : visibility_page;
          3'h5: core_control            <= merge16(core_control, wdata, wstrb);
          default: begin
          end
        endcase
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ========================================================================
  // AXI4-Lite read channel
  wire [2:0] rd_code;

  assign arready = !rvalid;
  assign rd_code = reg_code(araddr);

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= `RESP_OKAY;
    end else begin
      if (arvalid && !rvalid) begin
        rvalid <= 1'b1;
        rresp  <= (rd_code == 3'h0) ? `RESP_SLVERR : `RESP_OKAY;
        case (rd_code)
          3'h1:    rdata <= {16'h0000, addressing_mode_control};
          3'h2:    rdata <= {16'h0000, bit_reverse_control};
          3'h3:    rdata <= {24'h000000, table_page};
          3'h4:    rdata <= {24'h000000, visibility_page};
          3'h5:    rdata <= {16'h0000, core_control};
          3'h6:    rdata <= {8'h00, prog_addr};
          3'h7:    rdata <= {16'h0000, xw_ea};
          default: rdata <= 32'h00000000;
        endcase
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ========================================================================
  // X write address generator
  wire        is_inc;
  wire        is_dec;
  wire        is_pre;
  wire        bitrev_cond;
  wire [15:0] step;
  wire [15:0] normal_next;
  wire [15:0] bitrev_next;
  wire        xmod_match;

  assign is_inc = (xw_mode == `AM_PRE_INC) || (xw_mode == `AM_POST_INC);
  assign is_dec = (xw_mode == `AM_PRE_DEC) || (xw_mode == `AM_POST_DEC);
  assign is_pre = (xw_mode == `AM_PRE_INC) || (xw_mode == `AM_PRE_DEC);

  // Only the selected pointer on the X write path, words, increment modes
  assign bitrev_cond = (bitrev_pointer_select != `PTR_DISABLED) &&
                       (xw_ptr_num == bitrev_pointer_select) &&
                       bitrev_enable && is_inc && !xw_byte;

  assign step        = xw_byte ? 16'h0001 : 16'h0002;
  assign normal_next = is_inc ? xw_ptr + step :
                       is_dec ? xw_ptr - step : xw_ptr;

  // Reverse-carry add; the increment offset plays no part here
  bitrev_adder #(
    .AW (16)
  ) u_bitrev (
    .base   (xw_ptr),
    .pivot  (pivot_modifier),
    .result (bitrev_next)
  );

  assign xmod_match = xmod_on && (xmod_ptr != `PTR_DISABLED) && (xw_ptr_num == xmod_ptr);

  always @(posedge aclk) begin
    if (!aresetn) begin
      xw_done        <= 1'b0;
      xw_ea          <= 16'h0000;
      xw_ptr_next    <= 16'h0000;
      xw_ptr_wb      <= 1'b0;
      xw_bitrev_used <= 1'b0;
      xw_modulo_en   <= 1'b0;
      xr_modulo_en   <= 1'b0;
    end else begin
      xw_done      <= xw_req;
      // Circular correction on reads is unaffected by reversal
      xr_modulo_en <= xmod_on && (xmod_ptr != `PTR_DISABLED);
      if (xw_req) begin
        xw_bitrev_used <= bitrev_cond;
        xw_ptr_wb      <= is_inc || is_dec;
        xw_modulo_en   <= xmod_match && !bitrev_cond;
        if (bitrev_cond) begin
          xw_ptr_next <= bitrev_next;
          xw_ea       <= is_pre ? bitrev_next : {xw_ptr[15:1], 1'b0};
        end else begin
          xw_ptr_next <= normal_next;
          xw_ea       <= is_pre ? normal_next : xw_ptr;
        end
      end
    end
  end

  // ========================================================================
  // Program space address construction
  wire psv_hit;

  // Table operations suspend visibility remapping
  assign psv_hit = !pa_table && pa_ea[15] && visibility_enable;

  always @(posedge aclk) begin
    if (!aresetn) begin
      pa_done      <= 1'b0;
      prog_addr    <= 24'h000000;
      prog_config  <= 1'b0;
      prog_psv     <= 1'b0;
      prog_write   <= 1'b0;
      prog_refused <= 1'b0;
    end else begin
      pa_done      <= pa_req && (pa_table || (psv_hit && !pa_write));
      prog_refused <= pa_req && psv_hit && pa_write;
      if (pa_req && pa_table) begin
        prog_addr   <= {table_page, pa_ea};
        prog_config <= table_page[`TBL_CONFIG_BIT];
        prog_psv    <= 1'b0;
        prog_write  <= pa_write;
      end else if (pa_req && psv_hit && !pa_write) begin
        // Bit 15 comes from the page, since data bit 15 is always set here
        prog_addr   <= {1'b0, visibility_page, pa_ea[14:0]};
        prog_config <= 1'b0;
        prog_psv    <= 1'b1;
        prog_write  <= 1'b0;
      end
    end
  end

endmodule

/* File: agu_defs.vh */
/*
 * Constants for the bit-reversed and program-space address generator:
 * register byte offsets, field positions, reset values, addressing mode codes
 * and bus response codes.
 * Assumes inclusion by bare name from the design files that need it.
 */
`ifndef AGU_DEFS_VH
`define AGU_DEFS_VH

// ==========================================================================
// Register byte offsets
`define OFS_MODE_CTRL      8'h00
`define OFS_BITREV_CTRL    8'h04
`define OFS_TABLE_PAGE     8'h08
`define OFS_VIS_PAGE       8'h0C
`define OFS_CORE_CTRL      8'h10
`define OFS_LAST_PROG      8'h14
`define OFS_LAST_XW        8'h18

// ==========================================================================
// Field positions
`define XMOD_EN_BIT        15
`define SEL_HI             11
`define SEL_LO             8
`define XMOD_PTR_HI        3
`define XMOD_PTR_LO        0
`define BITREV_EN_BIT      15
`define PIVOT_HI           14
`define PIVOT_LO           0
`define TBL_CONFIG_BIT     7
`define VIS_EN_BIT         2
`define PTR_DISABLED       4'hF

// ==========================================================================
// Reset values
`define RST_MODE_CTRL      16'h0FFF
`define RST_BITREV_CTRL    16'h0000
`define RST_TABLE_PAGE     8'h00
`define RST_VIS_PAGE       8'h00
`define RST_CORE_CTRL      16'h0000

// ==========================================================================
// Indirect addressing mode codes
`define AM_INDIRECT        3'h0
`define AM_POST_DEC        3'h1
`define AM_POST_INC        3'h2
`define AM_PRE_DEC         3'h3
`define AM_PRE_INC         3'h4
`define AM_OFFSET          3'h5

// ==========================================================================
// Bus responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

/* File: bitrev_adder.v */
/*
 * Reverse-carry adder: adds a word pivot, scaled to bytes, to a byte pointer
 * with carries running from the top bit downward.
 * Assumes word data; the pointer's bit 0 is ignored and the result's is clear.
 */
`timescale 1ns/1ps

module bitrev_adder #(
  parameter AW = 16
) (
  input  wire [AW-1:0] base,
  input  wire [AW-2:0] pivot,
  output wire [AW-1:0] result
);

  wire [AW-1:0] base_even;
  wire [AW-1:0] scaled;
  wire [AW-1:0] rev_base;
  wire [AW-1:0] rev_pivot;
  wire [AW-1:0] rev_sum;
  wire [AW-1:0] sum_back;

  // ========================================================================
  // Reversal wiring
  assign base_even = {base[AW-1:1], 1'b0};
  assign scaled    = {pivot, 1'b0};

  genvar i;
  generate
    for (i = 0; i < AW; i = i + 1) begin : g_rev
      assign rev_base[i]  = base_even[AW-1-i];
      assign rev_pivot[i] = scaled[AW-1-i];
      assign sum_back[i]  = rev_sum[AW-1-i];
    end
  endgenerate

  // Carry out of the top of the reversed sum is dropped on purpose
  assign rev_sum = rev_base + rev_pivot;
  assign result  = {sum_back[AW-1:1], 1'b0};

endmodule

/* File: agu_checker_properties.sv */
/* Concurrent checks on the address generator's pipeline-side ports.
   Assumes binding to the top module, one clock, synchronous low reset. */
`timescale 1ns/1ps
module agu_checker (
  input wire        aclk,
  input wire        aresetn,
  input wire        xw_req,
  input wire [2:0]  xw_mode,
  input wire        xw_byte,
  input wire [15:0] xw_ptr,
  input wire        xw_done,
  input wire [15:0] xw_ea,
  input wire [15:0] xw_ptr_next,
  input wire        xw_bitrev_used,
  input wire        xw_modulo_en,
  input wire        pa_req,
  input wire        pa_table,
  input wire        pa_write,
  input wire [15:0] pa_ea,
  input wire        pa_done,
  input wire [23:0] prog_addr,
  input wire        prog_config,
  input wire        prog_psv,
  input wire        prog_write,
  input wire        prog_refused
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ====
  // X write generator
  chk_done_pulse: assert property (xw_req |=> xw_done)
    else $error("no done after request");
  chk_bitrev_gate: assert property (xw_req && (xw_byte || (xw_mode != 3'h2 &&
    xw_mode != 3'h4)) |=> !xw_bitrev_used) else $error("reversal outside its modes");
  chk_bitrev_word: assert property (xw_done && xw_bitrev_used |->
    !xw_ptr_next[0] && !xw_ea[0] && !xw_modulo_en) else $error("reversed result bad");
  chk_plain_inc: assert property (xw_req && !xw_byte && xw_mode == 3'h2 |=> xw_bitrev_used
    || (xw_ptr_next == $past(xw_ptr) + 16'h0002 && xw_ea == $past(xw_ptr)))
    else $error("ordinary increment wrong");
  // ====
  // Program space
  chk_table_addr: assert property (pa_req && pa_table |=> pa_done && !prog_psv &&
    prog_addr[15:0] == $past(pa_ea) && prog_config == prog_addr[23])
    else $error("table address wrong");
  chk_psv_user: assert property (pa_done && prog_psv |->
    !prog_addr[23] && !prog_write && !prog_config) else $error("remap left user space");
  chk_psv_low: assert property (pa_req && !pa_table && pa_ea[15] |=> !pa_done ||
    {1'b1, prog_addr[14:0]} == $past(pa_ea)) else $error("remap low bits wrong");
  chk_psv_refuse: assert property (pa_req && !pa_table && pa_write && pa_ea[15]
    |=> !pa_done) else $error("remapped write accepted");
  chk_psv_lower: assert property (pa_req && !pa_table && !pa_ea[15]
    |=> !pa_done && !prog_refused) else $error("lower half remapped");
  cov_bitrev: cover property (xw_done && xw_bitrev_used);
  cov_psv: cover property (pa_done && prog_psv);
  cov_config: cover property (pa_done && prog_config);
  cov_refused: cover property (prog_refused);
endmodule

bind bitrev_and_program_space_agu agu_checker u_agu_checker (
  .aclk, .aresetn, .xw_req, .xw_mode, .xw_byte, .xw_ptr, .xw_done, .xw_ea,
  .xw_ptr_next, .xw_bitrev_used, .xw_modulo_en, .pa_req, .pa_table, .pa_write,
  .pa_ea, .pa_done, .prog_addr, .prog_config, .prog_psv, .prog_write, .prog_refused
);

/* File: cpu_pipe_model.sv */
/* Pipeline model: issues X write and program space address requests.
   Assumes aclk from the bench; each request lasts one cycle. */
`timescale 1ns/1ps
module cpu_pipe_model (
  input  wire        aclk,
  output reg         xw_req = 1'h0,
  output reg  [3:0]  xw_ptr_num = 4'h0,
  output reg  [15:0] xw_ptr = 16'h0000,
  output reg  [2:0]  xw_mode = 3'h0,
  output reg         xw_byte = 1'h0,
  output reg         pa_req = 1'h0,
  output reg         pa_table = 1'h0,
  output reg         pa_write = 1'h0,
  output reg  [15:0] pa_ea = 16'h0000
);
  // ====
  // Callers keep buffer bases aligned to the buffer length
  // Both circular and reversed modes on only for the priority check
  // No read through the reversed pointer follows a control write
  task issue_xw(input [3:0] n, input [15:0] pt, input [2:0] m, input bw);
    begin
      @(posedge aclk);
      xw_req     <= 1'h1;
      xw_ptr_num <= n;
      xw_ptr     <= pt;
      xw_mode    <= m;
      xw_byte    <= bw;
      @(posedge aclk);
      xw_req <= 1'h0;
      // Stale pointer would hide a design that samples late
      xw_ptr <= ~pt;
      #1;
    end
  endtask
  task issue_pa(input tb, input wr, input [15:0] ea);
    begin
      @(posedge aclk);
      pa_req   <= 1'h1;
      pa_table <= tb;
      pa_write <= wr;
      pa_ea    <= ea;
      @(posedge aclk);
      pa_req <= 1'h0;
      pa_ea  <= ~ea;
      #1;
    end
  endtask
endmodule

/* File: tb_top.sv */
/* Self-checking bench for the address generator.
   Assumes the register map and mode codes of agu_defs.vh. */
`timescale 1ns/1ps
`include "agu_defs.vh"
module tb_top;
  reg         aclk = 1'h0;
  reg         aresetn = 1'h0;
  reg  [7:0]  awaddr = 8'h00, araddr = 8'h00;
  reg  [31:0] wdata = 32'h0;
  reg         awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  wire        awready, wready, bvalid, arready, rvalid, xw_req, xw_byte, xw_done;
  wire        xw_ptr_wb, xw_bitrev_used, xw_modulo_en, xr_modulo_en, pa_req, pa_table;
  wire        pa_write, pa_done, prog_config, prog_psv, prog_write, prog_refused;
  wire [1:0]  bresp, rresp;
  wire [2:0]  xw_mode;
  wire [3:0]  xw_ptr_num;
  wire [15:0] xw_ptr, xw_ea, xw_ptr_next, pa_ea;
  wire [23:0] prog_addr;
  wire [31:0] rdata;
  integer     n_errors = 0, comparisons = 0, k;
  reg  [31:0] d;
  reg  [1:0]  r;
  reg  [15:0] p, e;
  always #2.5 aclk = ~aclk;
  cpu_pipe_model cpu (.aclk, .xw_req, .xw_ptr_num, .xw_ptr, .xw_mode, .xw_byte,
    .pa_req, .pa_table, .pa_write, .pa_ea);
  bitrev_and_program_space_agu #(.ADDR_W(8)) DUT (.aclk, .aresetn, .awaddr, .awprot(3'h0),
    .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .xw_req, .xw_ptr_num, .xw_ptr, .xw_mode, .xw_byte, .xw_done, .xw_ea, .xw_ptr_next,
    .xw_ptr_wb, .xw_bitrev_used, .xw_modulo_en, .xr_modulo_en, .pa_req, .pa_table,
    .pa_write, .pa_ea, .pa_done, .prog_addr, .prog_config, .prog_psv, .prog_write,
    .prog_refused);
  // ====
  // Shared tasks
  function [3:0] rev4(input [3:0] v);
    rev4 = {v[0], v[1], v[2], v[3]};
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task axi_write(input [7:0] a, input [31:0] dv);
    begin
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= dv;
      awvalid <= 1'h1;
      wvalid  <= 1'h1;
      bready  <= 1'h1;
      @(posedge aclk);
      while (!(awready && wready)) @(posedge aclk);
      awvalid <= 1'h0;
      wvalid  <= 1'h0;
      @(posedge aclk);
      while (!bvalid) @(posedge aclk);
      r = bresp;
      bready <= 1'h0;
    end
  endtask
  task axi_read(input [7:0] a);
    begin
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'h1;
      rready  <= 1'h1;
      @(posedge aclk);
      while (!arready) @(posedge aclk);
      arvalid <= 1'h0;
      @(posedge aclk);
      while (!rvalid) @(posedge aclk);
      d = rdata;
      r = rresp;
      rready <= 1'h0;
    end
  endtask
  task wr(input [7:0] a, input [31:0] dv);
    begin
      axi_write(a, dv);
      check(r, `RESP_OKAY);
    end
  endtask
  task rd_chk(input [7:0] a, input [31:0] exp);
    begin
      axi_read(a);
      check(r, `RESP_OKAY);
      check(d, exp);
    end
  endtask
  task xw_chk(input [3:0] n, input [15:0] pt, input [2:0] m, input bw,
              input [15:0] nx, input [15:0] ea, input br);
    begin
      cpu.issue_xw(n, pt, m, bw);
      check(xw_done, 32'h1);
      check(xw_bitrev_used, br);
      check(xw_ptr_next, nx);
      check(xw_ea, ea);
    end
  endtask
  task summarize;
    begin
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // ====
  // Tests; whole run is about 140 cycles
  initial begin
    #50000;
    n_errors = n_errors + 1;
    summarize;
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    rd_chk(`OFS_MODE_CTRL, {16'h0000, `RST_MODE_CTRL});
    rd_chk(`OFS_BITREV_CTRL, {16'h0000, `RST_BITREV_CTRL});
    rd_chk(`OFS_VIS_PAGE, {24'h000000, `RST_VIS_PAGE});
    axi_read(8'h1C);
    check(r, `RESP_SLVERR);
    axi_write(8'h1C, 32'h0000FFFF);
    check(r, `RESP_SLVERR);
    wr(`OFS_MODE_CTRL, 32'h000004FF);
    wr(`OFS_BITREV_CTRL, 32'hFFFF8008);
    rd_chk(`OFS_BITREV_CTRL, 32'h00008008);
    for (k = 0; k < 16; k = k + 1) begin
      p = 16'h0100 + {rev4(k[3:0]), 1'h0};
      e = 16'h0100 + {rev4(k[3:0] + 4'h1), 1'h0};
      xw_chk(4'h4, p, k[0] ? `AM_PRE_INC : `AM_POST_INC, 1'h0, e, k[0] ? e : p, 1'h1);
    end
    for (k = 0; k < 6; k = k + 1) begin
      cpu.issue_xw(4'h4, 16'h0100, k[2:0], 1'h0);
      check(xw_bitrev_used, (k == 2 || k == 4) ? 32'h1 : 32'h0);
      check(xw_ptr_wb, (k != 0 && k != 5) ? 32'h1 : 32'h0);
      check(xw_ptr_next, (k == 2 || k == 4) ? 32'h0110 : (k == 1 || k == 3) ? 32'h00FE : 32'h0100);
    end
    xw_chk(4'h4, 16'h0101, `AM_PRE_INC, 1'h1, 16'h0102, 16'h0102, 1'h0);
    xw_chk(4'h5, 16'h0110, `AM_POST_INC, 1'h0, 16'h0112, 16'h0110, 1'h0);
    wr(`OFS_MODE_CTRL, 32'h000084F4);
    xw_chk(4'h4, 16'h0100, `AM_POST_INC, 1'h0, 16'h0110, 16'h0100, 1'h1);
    check(xw_modulo_en, 32'h0);
    check(xr_modulo_en, 32'h1);
    wr(`OFS_BITREV_CTRL, 32'h00000008);
    xw_chk(4'h4, 16'h0100, `AM_POST_INC, 1'h0, 16'h0102, 16'h0100, 1'h0);
    check(xw_modulo_en, 32'h1);
    wr(`OFS_MODE_CTRL, 32'h00000FFF);
    wr(`OFS_BITREV_CTRL, 32'h00008008);
    xw_chk(4'hF, 16'h0200, `AM_POST_INC, 1'h0, 16'h0202, 16'h0200, 1'h0);
    wr(`OFS_TABLE_PAGE, 32'h00000085);
    cpu.issue_pa(1'h1, 1'h0, 16'h1234);
    check({pa_done, prog_config, prog_addr}, {2'h3, 24'h851234});
    wr(`OFS_TABLE_PAGE, 32'h00000012);
    cpu.issue_pa(1'h1, 1'h1, 16'hFFFF);
    check({pa_done, prog_write, prog_config, prog_addr}, {3'h6, 24'h12FFFF});
    wr(`OFS_CORE_CTRL, 32'h00000004);
    cpu.issue_pa(1'h1, 1'h0, 16'h8000);
    check({prog_psv, prog_addr}, {1'h0, 24'h128000});
    wr(`OFS_VIS_PAGE, 32'h00000081);
    cpu.issue_pa(1'h0, 1'h0, 16'hC234);
    check({pa_done, prog_psv, prog_config, prog_addr}, {3'h6, 24'h40C234});
    wr(`OFS_VIS_PAGE, 32'h00000080);
    cpu.issue_pa(1'h0, 1'h0, 16'hC234);
    check({pa_done, prog_addr}, {1'h1, 24'h404234});
    cpu.issue_pa(1'h0, 1'h1, 16'hC000);
    check({pa_done, prog_refused, prog_addr}, {2'h1, 24'h404234});
    cpu.issue_pa(1'h0, 1'h0, 16'h4000);
    check({pa_done, prog_refused}, 32'h0);
    wr(`OFS_CORE_CTRL, 32'h00000000);
    cpu.issue_pa(1'h0, 1'h0, 16'hC234);
    check({pa_done, prog_refused}, 32'h0);
    wr(`OFS_LAST_PROG, 32'h00000000);
    rd_chk(`OFS_LAST_PROG, 32'h00404234);
    summarize;
  end
endmodule
